//--- sltc_consts.vh
/*
 Constants for the sleep timer compare and interrupt register block.
 Assumes byte addresses on a 32-bit word register port.
*/
`ifndef SLTC_CONSTS_VH
`define SLTC_CONSTS_VH

`define SLTC_ADDR_CLKEN      32'h4000_0008
`define SLTC_ADDR_CFG        32'h4000_600C
`define SLTC_ADDR_CNTH       32'h4000_6010
`define SLTC_ADDR_CNTL       32'h4000_6014
`define SLTC_ADDR_CMPAH      32'h4000_6018
`define SLTC_ADDR_CMPAL      32'h4000_601C
`define SLTC_ADDR_CMPBH      32'h4000_6020
`define SLTC_ADDR_CMPBL      32'h4000_6024
`define SLTC_ADDR_FLAGS      32'h4000_A014
`define SLTC_ADDR_MASK       32'h4000_A054
`define SLTC_ADDR_SLEEP      32'h4000_A100

`define SLTC_CMP_RST         16'hFFFF
`define SLTC_CLKEN_RST       2'h2
`define SLTC_BIT_CMPB        2
`define SLTC_BIT_CMPA        1
`define SLTC_BIT_WRAP        0
`define SLTC_BIT_RC          1
`define SLTC_BIT_XTAL        0
`define SLTC_BIT_RUN         11
`define SLTC_BIT_DEEP        0

`endif

//--- sltc_sleep_timer.v
/*
 Register side of a 32-bit sleep timer: split counter read, two compare
 values loaded through hold registers, event flags with mask, clock
 source enables and deep sleep variant choice.
 Assumes one clock; the register port strobes are one cycle long and
 read data is expected exactly one cycle after the read strobe.
*/
// Operation
// - Reading counter high half latches current counter low 16 bits.
// - Compare A low write goes to hold register only.
// - Compare B low write goes to hold register only.
// - Compare high write loads high bits and transfers held low bits.
// - All four compare halves reset to 16'hFFFF.
// - Flags: compare B bit 2, compare A bit 1, wrap bit 0.
// - Writing one clears a flag; writing zero leaves it.
// - Mask register has one enable per event, same positions, resets zero.
// - RC keep-on bit 1 keeps low-frequency RC running in deep sleep.
// - Crystal enable bit 0 enables external crystal clock source.
// - Deep sleep with RC bit clear stops timer; set keeps it running.
// - Clock source enables reset with RC set, crystal clear.
// - Each event serves as interrupt request and wake-up event.
// - Timer run bit starts counter when one, stops it when zero.
`include "sltc_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module sltc_sleep_timer #(
	parameter NUM_EVT = 3
) (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        timer_tick,
	input  wire [31:0] addr,
	input  wire [31:0] wdata,
	input  wire        wr_stb,
	input  wire        rd_stb,
	output reg  [31:0] rdata,
	output wire        timer_irq,
	output wire        wake_event,
	output wire        rc_osc_keep_on,
	output wire        crystal_osc_enable,
	output wire        deep_sleep_timer_on,
	output wire        deep_sleep_timer_off,
	output wire        timer_running
);

	reg  [31:0]        count;
	reg  [15:0]        counter_low_word;
	reg  [31:0]        cmp_a;
	reg  [31:0]        cmp_b;
	reg  [15:0]        hold_a;
	reg  [15:0]        hold_b;
	reg  [NUM_EVT-1:0] flags;
	reg  [NUM_EVT-1:0] mask;
	reg  [1:0]         clken;
	reg                run;
	reg                deep_sleep_select;
	wire [NUM_EVT-1:0] evt;
	wire [NUM_EVT-1:0] clr;
	wire               step;

	// Register port address decode, shared by every write strobe below and the counter high read
	function wr_hit;
		input [31:0] a;
		input [31:0] target;
		input        stb;
		begin
			wr_hit = stb && (a == target);
		end
	endfunction

	wire we_cfg   = wr_hit(addr, `SLTC_ADDR_CFG, wr_stb);
	wire we_cmpah = wr_hit(addr, `SLTC_ADDR_CMPAH, wr_stb);
	wire we_cmpal = wr_hit(addr, `SLTC_ADDR_CMPAL, wr_stb);
	wire we_cmpbh = wr_hit(addr, `SLTC_ADDR_CMPBH, wr_stb);
	wire we_cmpbl = wr_hit(addr, `SLTC_ADDR_CMPBL, wr_stb);
	wire we_flags = wr_hit(addr, `SLTC_ADDR_FLAGS, wr_stb);
	wire we_mask  = wr_hit(addr, `SLTC_ADDR_MASK, wr_stb);
	wire we_clken = wr_hit(addr, `SLTC_ADDR_CLKEN, wr_stb);
	wire we_sleep = wr_hit(addr, `SLTC_ADDR_SLEEP, wr_stb);
	wire re_cnth  = wr_hit(addr, `SLTC_ADDR_CNTH, rd_stb);

	// Counter steps only on a tick while running
	assign step = run && timer_tick;

	// Counter is frozen in the deeper sleep variant, since its clock is off
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= 32'h0000_0000;
		end else if (step && !deep_sleep_timer_off) begin
			count <= count + 32'h0000_0001;
		end
	end

	assign timer_running = run && !deep_sleep_timer_off;

	// Events fire once per step that lands on the compare value or wraps
	assign evt[`SLTC_BIT_CMPB] = step && !deep_sleep_timer_off &&
		(count + 32'h0000_0001 == cmp_b);
	assign evt[`SLTC_BIT_CMPA] = step && !deep_sleep_timer_off &&
		(count + 32'h0000_0001 == cmp_a);
	assign evt[`SLTC_BIT_WRAP] = step && !deep_sleep_timer_off &&
		(count == 32'hFFFF_FFFF);

	assign clr = we_flags ? wdata[NUM_EVT-1:0] : {NUM_EVT{1'b0}};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_EVT; gi = gi + 1) begin : g_flag
			// Set wins over a clear landing in the same cycle
			always @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					flags[gi] <= 1'b0;
				end else if (evt[gi]) begin
					flags[gi] <= 1'b1;
				end else if (clr[gi]) begin
					flags[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	assign timer_irq  = |(flags & mask);
	assign wake_event = |(flags & mask);

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask              <= {NUM_EVT{1'b0}};
			clken             <= `SLTC_CLKEN_RST;
			run               <= 1'b0;
			deep_sleep_select <= 1'b0;
		end else begin
			if (we_mask) begin
				mask <= wdata[NUM_EVT-1:0];
			end
			if (we_clken) begin
				clken <= wdata[1:0];
			end
			if (we_cfg) begin
				run <= wdata[`SLTC_BIT_RUN];
			end
			if (we_sleep) begin
				deep_sleep_select <= wdata[`SLTC_BIT_DEEP];
			end else if (|(flags & mask)) begin
				// A wake event ends deep sleep
				deep_sleep_select <= 1'b0;
			end
		end
	end

	assign rc_osc_keep_on     = clken[`SLTC_BIT_RC];
	assign crystal_osc_enable = clken[`SLTC_BIT_XTAL];
	assign deep_sleep_timer_on  = deep_sleep_select &&
		clken[`SLTC_BIT_RC];
	assign deep_sleep_timer_off = deep_sleep_select &&
		!clken[`SLTC_BIT_RC];

	// Compare values; no interlock with run, software must stop first
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmp_a  <= {`SLTC_CMP_RST, `SLTC_CMP_RST};
			cmp_b  <= {`SLTC_CMP_RST, `SLTC_CMP_RST};
			hold_a <= `SLTC_CMP_RST;
			hold_b <= `SLTC_CMP_RST;
		end else begin
			if (we_cmpal) begin
				hold_a <= wdata[15:0];
			end
			if (we_cmpbl) begin
				hold_b <= wdata[15:0];
			end
			if (we_cmpah) begin
				cmp_a <= {wdata[15:0], hold_a};
			end
			if (we_cmpbh) begin
				cmp_b <= {wdata[15:0], hold_b};
			end
		end
	end

	// Low half snapshot taken on a high half read
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			counter_low_word <= 16'h0000;
		end else if (re_cnth) begin
			counter_low_word <= count[15:0];
		end
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata <= 32'h0000_0000;
		end else if (!rd_stb) begin
			rdata <= 32'h0000_0000;
		end else begin
			case (addr)
			`SLTC_ADDR_CFG:   rdata <= {20'h0_0000, run, 11'h000};
			`SLTC_ADDR_CNTH:  rdata <= {16'h0000, count[31:16]};
			`SLTC_ADDR_CNTL:  rdata <= {16'h0000, counter_low_word};
			`SLTC_ADDR_CMPAH: rdata <= {16'h0000, cmp_a[31:16]};
			`SLTC_ADDR_CMPAL: rdata <= {16'h0000, cmp_a[15:0]};
			`SLTC_ADDR_CMPBH: rdata <= {16'h0000, cmp_b[31:16]};
			`SLTC_ADDR_CMPBL: rdata <= {16'h0000, cmp_b[15:0]};
			`SLTC_ADDR_FLAGS: rdata <= {{(32-NUM_EVT){1'b0}}, flags};
			`SLTC_ADDR_MASK:  rdata <= {{(32-NUM_EVT){1'b0}}, mask};
			`SLTC_ADDR_CLKEN: rdata <= {30'h0000_0000, clken};
			`SLTC_ADDR_SLEEP: rdata <= {31'h0000_0000, deep_sleep_select};
			default:          rdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule // sltc_sleep_timer

`default_nettype wire

//--- sltc_monitor.sv
/*
 Checker for the sleep timer register block, bound to its ports.
 Assumes one clock and the one-cycle strobe register port.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sltc_consts.vh"
module sltc_monitor (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        timer_tick,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [31:0] rdata,
	input wire logic        timer_irq,
	input wire logic        wake_event,
	input wire logic        rc_osc_keep_on,
	input wire logic        crystal_osc_enable,
	input wire logic        deep_sleep_timer_on,
	input wire logic        deep_sleep_timer_off,
	input wire logic        timer_running
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_mask_wr;
		wr_stb && addr == `SLTC_ADDR_MASK;
	endsequence
	sequence s_mask_rd;
		rd_stb && addr == `SLTC_ADDR_MASK;
	endsequence
	a_mask_readback: assert property (
		s_mask_wr ##2 s_mask_rd |=> rdata == {29'h0, $past(wdata[2:0], 3)})
		else $error("mask readback wrong");
	a_wake_follows: assert property (wake_event == timer_irq)
		else $error("wake differs from irq");
	a_sleep_on_rc: assert property (deep_sleep_timer_on |->
		rc_osc_keep_on && !deep_sleep_timer_off)
		else $error("timer-on sleep without rc");
	a_sleep_off_rc: assert property (deep_sleep_timer_off |->
		!rc_osc_keep_on && !timer_running)
		else $error("timer-off sleep wrong");
	a_clken_write: assert property (
		wr_stb && addr == `SLTC_ADDR_CLKEN |=>
		{rc_osc_keep_on, crystal_osc_enable} == $past(wdata[1:0]))
		else $error("clock enables not loaded");
	a_clken_hold: assert property (
		!(wr_stb && addr == `SLTC_ADDR_CLKEN) |=>
		$stable({rc_osc_keep_on, crystal_osc_enable}))
		else $error("clock enables moved");
	a_run_write: assert property (wr_stb && addr == `SLTC_ADDR_CFG |=>
		timer_running == ($past(wdata[11]) && !deep_sleep_timer_off))
		else $error("run bit not followed");
	a_irq_masked: assert property (
		wr_stb && addr == `SLTC_ADDR_MASK && wdata[2:0] == 3'h0 |=> !timer_irq)
		else $error("irq with mask clear");
	a_flag_clear: assert property (
		wr_stb && addr == `SLTC_ADDR_FLAGS && wdata[2:0] == 3'h7 && !timer_tick
		|=> !timer_irq)
		else $error("flags not cleared");
endmodule // sltc_monitor
bind sltc_sleep_timer sltc_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
	.timer_tick(timer_tick), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
	.rd_stb(rd_stb), .rdata(rdata), .timer_irq(timer_irq),
	.wake_event(wake_event), .rc_osc_keep_on(rc_osc_keep_on),
	.crystal_osc_enable(crystal_osc_enable),
	.deep_sleep_timer_on(deep_sleep_timer_on),
	.deep_sleep_timer_off(deep_sleep_timer_off),
	.timer_running(timer_running));
`default_nettype wire

//--- sleep_timer_compare_irq_bench.sv
/*
 Self-checking bench for the sleep timer register block.
 Assumes read data one cycle after the read strobe.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sltc_consts.vh"
module sleep_timer_compare_irq_bench;
	logic        clk, sys_rst, timer_tick, wr_stb, rd_stb;
	logic [31:0] addr, wdata;
	wire  [31:0] rdata;
	wire         timer_irq, wake_event, rc_osc_keep_on, crystal_osc_enable;
	wire         deep_sleep_timer_on, deep_sleep_timer_off, timer_running;
	int          n_mismatch, comparisons, i;
	logic [31:0] ra [7] = '{`SLTC_ADDR_CMPAH, `SLTC_ADDR_CMPAL,
		`SLTC_ADDR_CMPBH, `SLTC_ADDR_CMPBL, `SLTC_ADDR_CLKEN,
		`SLTC_ADDR_FLAGS, `SLTC_ADDR_MASK};
	logic [31:0] rv [7] = '{32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF,
		32'h0000_FFFF, 32'h0000_0002, 32'h0000_0000, 32'h0000_0000};
	sltc_sleep_timer uut (.clk(clk), .sys_rst(sys_rst),
		.timer_tick(timer_tick), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .timer_irq(timer_irq),
		.wake_event(wake_event), .rc_osc_keep_on(rc_osc_keep_on),
		.crystal_osc_enable(crystal_osc_enable),
		.deep_sleep_timer_on(deep_sleep_timer_on),
		.deep_sleep_timer_off(deep_sleep_timer_off),
		.timer_running(timer_running));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		#1;
	endtask
	task rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 check(rdata, exp);
	endtask
	// Ticks are back to back, the harshest spacing the counter can see
	task tick(input int n);
		repeat (n) begin
			@(posedge clk);
			timer_tick <= 1'b1;
		end
		@(posedge clk);
		timer_tick <= 1'b0;
		#1;
	endtask
	task conclude;
		$display("n_mismatch=%0d comparisons=%0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		conclude();
	end
	initial begin
		{sys_rst, timer_tick, wr_stb, rd_stb} = 4'h8;
		{addr, wdata} = 64'h0;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		for (i = 0; i < 7; i++)
			rd(ra[i], rv[i]);
		check({rc_osc_keep_on, crystal_osc_enable}, 32'h2);
		rd(32'h4000_7000, 32'h0);
		wr(`SLTC_ADDR_MASK, 32'h7);
		rd(`SLTC_ADDR_MASK, 32'h7);
		wr(`SLTC_ADDR_MASK, 32'h0);
		// Compares are loaded with the run bit clear to avoid false events
		wr(`SLTC_ADDR_CMPAL, 32'h8);
		wr(`SLTC_ADDR_CMPAH, 32'h0);
		wr(`SLTC_ADDR_CMPBL, 32'hA);
		wr(`SLTC_ADDR_CMPBH, 32'h0);
		wr(`SLTC_ADDR_CMPAL, 32'h4);
		wr(`SLTC_ADDR_CMPBL, 32'h9);
		wr(`SLTC_ADDR_MASK, 32'h2);
		wr(`SLTC_ADDR_CFG, 32'h0000_0800);
		tick(6);
		check(timer_irq, 32'h0);
		tick(2);
		check(timer_irq, 32'h1);
		check(wake_event, 32'h1);
		rd(`SLTC_ADDR_FLAGS, 32'h2);
		wr(`SLTC_ADDR_FLAGS, 32'h5);
		rd(`SLTC_ADDR_FLAGS, 32'h2);
		wr(`SLTC_ADDR_FLAGS, 32'h2);
		rd(`SLTC_ADDR_FLAGS, 32'h0);
		tick(1);
		rd(`SLTC_ADDR_FLAGS, 32'h0);
		tick(1);
		rd(`SLTC_ADDR_FLAGS, 32'h4);
		check(timer_irq, 32'h0);
		wr(`SLTC_ADDR_CFG, 32'h0);
		tick(3);
		rd(`SLTC_ADDR_CNTH, 32'h0);
		rd(`SLTC_ADDR_CNTL, 32'hA);
		wr(`SLTC_ADDR_CLKEN, 32'h1);
		check({rc_osc_keep_on, crystal_osc_enable}, 32'h1);
		wr(`SLTC_ADDR_CFG, 32'h0000_0800);
		wr(`SLTC_ADDR_SLEEP, 32'h1);
		check({deep_sleep_timer_on, deep_sleep_timer_off, timer_running},
			32'h2);
		wr(`SLTC_ADDR_CLKEN, 32'h2);
		check({deep_sleep_timer_on, deep_sleep_timer_off, timer_running},
			32'h5);
		wr(`SLTC_ADDR_SLEEP, 32'h0);
		wr(`SLTC_ADDR_MASK, 32'h0);
		wr(`SLTC_ADDR_FLAGS, 32'h7);
		rd(`SLTC_ADDR_FLAGS, 32'h0);
		conclude();
	end
endmodule // sleep_timer_compare_irq_bench
`default_nettype wire
